// file: ssr_host_model.sv
// host side register reader standing in for the serial frame logic
`timescale 1ns/1ps
module ssr_host_model
   import ssr_pkg::*;
(
   input  wire logic              clock_i,
   input  wire logic [BYTE_W-1:0] rd_data_i,
   input  wire logic              rd_valid_i,
   output logic                   rd_en_o,
   output logic      [ADDR_W-1:0] rd_addr_o
);
   // idle bus at time zero
   initial
   begin
      rd_en_o   = 1'b0;
      rd_addr_o = 5'h00;
   end

   // one read: request held over the taking edge, answer caught after it
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [BYTE_W-1:0] d,
                     output logic ok);
      int n;
      ok = 1'b0;
      d  = 8'h00;
      @(posedge clock_i);
      #1;
      rd_en_o   = 1'b1;
      rd_addr_o = a;
      @(posedge clock_i);
      #1;
      rd_en_o   = 1'b0;
      // stale address would hide a late decode, so show its inverse
      rd_addr_o = ~a;
      for (n = 0; n < 3 && ok !== 1'b1; n++)
      begin
         if (rd_valid_i === 1'b1)
         begin
            d  = rd_data_i;
            ok = 1'b1;
         end
         else
         begin
            @(posedge clock_i);
            #1;
         end
      end
   endtask
endmodule

// file: ssr_pkg.sv
// shared constants of the stepper status readout
package ssr_pkg;
   // widths of the status fields
   localparam int ADDR_W  = 5;
   localparam int BYTE_W  = 8;
   localparam int POS_W   = 7;
   localparam int MAG_W   = 5;
   localparam int SHORT_W = 4;
   localparam int SYNC_W  = 5;

   // register addresses, primary copy
   localparam logic [ADDR_W-1:0] ADDR_POS   = 5'h0a;
   localparam logic [ADDR_W-1:0] ADDR_BEMF  = 5'h0b;
   localparam logic [ADDR_W-1:0] ADDR_RATE  = 5'h0c;
   localparam logic [ADDR_W-1:0] ADDR_LOSS  = 5'h0d;
   localparam logic [ADDR_W-1:0] ADDR_XPWM  = 5'h0e;
   localparam logic [ADDR_W-1:0] ADDR_YPWM  = 5'h0f;
   localparam logic [ADDR_W-1:0] ADDR_XPINS = 5'h1e;
   localparam logic [ADDR_W-1:0] ADDR_YPINS = 5'h1f;
   // second copy of position, back-emf, rate and step loss
   localparam logic [ADDR_W-1:0] ADDR_ALIAS = 5'h10;

   // bit positions inside a status byte
   localparam int BIT_PAR = 7;
   localparam int BIT_HI  = 6;
   localparam int BIT_MID = 5;
   localparam int BIT_LO  = 4;

   // slots of the pin synchroniser
   localparam int SYNC_STEP = 0;
   localparam int SYNC_M0   = 1;
   localparam int SYNC_M1   = 2;
   localparam int SYNC_RH   = 3;
   localparam int SYNC_DIR  = 4;

   // reset and limit values
   localparam logic [POS_W-1:0]   LOSS_MAX      = 7'h7f;
   localparam logic [POS_W-1:0]   LOSS_RST      = 7'h00;
   localparam logic [POS_W-1:0]   LOSS_ONE      = 7'h01;
   localparam logic [SHORT_W-1:0] SHORT_RST     = 4'h0;
   localparam logic [SYNC_W-1:0]  SYNC_RST      = 5'h00;
   localparam logic [BYTE_W-1:0]  UNMAPPED_DATA = 8'h00;
endpackage

// file: ssr_status_regs.sv
// status register bank of the stepper driver, read by the serial interface
`timescale 1ns/1ps
// How it works
// - position in low seven bits
// - bit 6 names measured coil
// - bit 5 flags unexpected back-emf polarity
// - back-emf magnitude in low five bits
// - full byte speed, no check bit
// - count step pulses while steps ignored
// - step loss count saturates at 127
// - x pwm bit 6 top or bottom
// - x pwm bit 5 drive sign
// - x duty in low five bits
// - same layout for coil y
// - open coil flags in bit 6
// - step mode pins in bits 5,4
// - run/hold and direction pins bits 5,4
// - four x short flags bits 3..0
// - four y short flags same order
// - odd check bit 7 except speed
// - latched flags clear on read
module ssr_status_regs
   import ssr_pkg::*;
(
   input  wire logic              clock_i,
   input  wire logic              srst_i,
   input  wire logic              rd_en_i,
   input  wire logic [ADDR_W-1:0] rd_addr_i,
   input  wire logic [POS_W-1:0]  translator_position_i,
   input  wire logic              back_emf_coil_select_i,
   input  wire logic              back_emf_polarity_bad_i,
   input  wire logic [MAG_W-1:0]  back_emf_magnitude_i,
   input  wire logic [BYTE_W-1:0] rotor_rate_i,
   input  wire logic              step_pulse_input_i,
   input  wire logic              steps_ignored_i,
   input  wire logic              x_regulation_side_i,
   input  wire logic              x_drive_polarity_i,
   input  wire logic [MAG_W-1:0]  x_duty_value_i,
   input  wire logic              y_regulation_side_i,
   input  wire logic              y_drive_polarity_i,
   input  wire logic [MAG_W-1:0]  y_duty_value_i,
   input  wire logic              x_coil_broken_flag_i,
   input  wire logic              y_coil_broken_flag_i,
   input  wire logic              x_pos_ground_fault_i,
   input  wire logic              x_neg_ground_fault_i,
   input  wire logic              x_pos_supply_fault_i,
   input  wire logic              x_neg_supply_fault_i,
   input  wire logic              y_pos_ground_fault_i,
   input  wire logic              y_neg_ground_fault_i,
   input  wire logic              y_pos_supply_fault_i,
   input  wire logic              y_neg_supply_fault_i,
   input  wire logic              step_mode_bit0_level_i,
   input  wire logic              step_mode_bit1_level_i,
   input  wire logic              run_hold_input_level_i,
   input  wire logic              rotation_sense_input_level_i,
   output logic      [BYTE_W-1:0] rd_data_o,
   output logic                   rd_valid_o
);
   // odd check bit on top of seven payload bits
   // odd check bit
   function automatic logic [BYTE_W-1:0] odd_byte(input logic [POS_W-1:0] v);
      odd_byte = {~(^v), v};
   endfunction

   // address match allowing the optional second copy
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] base,
                                     input logic              aliased);
      addr_hit = (a == base) || (aliased && (a == (base | ADDR_ALIAS)));
   endfunction

   // registers that carry the check bit; speed and unmapped holes do not
   function automatic logic has_check(input logic [ADDR_W-1:0] a);
      has_check = addr_hit(a, ADDR_POS, 1'b1) || addr_hit(a, ADDR_BEMF, 1'b1)
                  || addr_hit(a, ADDR_LOSS, 1'b1) || addr_hit(a, ADDR_XPWM, 1'b0)
                  || addr_hit(a, ADDR_YPWM, 1'b0) || addr_hit(a, ADDR_XPINS, 1'b0)
                  || addr_hit(a, ADDR_YPINS, 1'b0);
   endfunction

   logic [SYNC_W-1:0]  pin_sync;
   logic               step_prev;
   logic               step_edge;
   logic               lost_step;
   logic [POS_W-1:0]   step_loss;
   logic [POS_W-1:0]   next_step_loss;
   logic               x_open;
   logic               y_open;
   logic [SHORT_W-1:0] x_short;
   logic [SHORT_W-1:0] y_short;
   logic [SHORT_W-1:0] x_short_evt;
   logic [SHORT_W-1:0] y_short_evt;
   logic               rd_loss;
   logic               rd_xpins;
   logic               rd_ypins;
   logic [BYTE_W-1:0]  next_rd_data;

   // pins arrive from outside the clock domain
   ssr_sync2 u_pin_sync
   (
      .clock_i (clock_i),
      .srst_i  (srst_i),
      .async_i ({rotation_sense_input_level_i,
                 run_hold_input_level_i,
                 step_mode_bit1_level_i,
                 step_mode_bit0_level_i,
                 step_pulse_input_i}),
      .sync_o  (pin_sync)
   );

   // rising edge of the synchronised step pulse
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
         step_prev <= 1'b0;
      else
         step_prev <= pin_sync[SYNC_STEP];
   end

   assign step_edge = pin_sync[SYNC_STEP] & ~step_prev;
   // pulse counts only while steps ignored
   assign lost_step = step_edge & steps_ignored_i;

   // read strobes that clear latched flags
   // alias address clears like primary
   assign rd_loss  = rd_en_i && addr_hit(rd_addr_i, ADDR_LOSS, 1'b1);
   assign rd_xpins = rd_en_i && addr_hit(rd_addr_i, ADDR_XPINS, 1'b0);
   assign rd_ypins = rd_en_i && addr_hit(rd_addr_i, ADDR_YPINS, 1'b0);

   // short fault events in register bit order
   // x shorts bits 3..0
   assign x_short_evt = {x_pos_ground_fault_i, x_neg_ground_fault_i,
                         x_pos_supply_fault_i, x_neg_supply_fault_i};
   assign y_short_evt = {y_pos_ground_fault_i, y_neg_ground_fault_i,
                         y_pos_supply_fault_i, y_neg_supply_fault_i};

   // step loss next value; a pulse in the read cycle survives the clear
   always_comb
   begin
      next_step_loss = step_loss;
      if (rd_loss)
         next_step_loss = LOSS_RST;
      if (lost_step)
      begin
         if (rd_loss)
            next_step_loss = LOSS_ONE;
         else if (step_loss != LOSS_MAX)
            next_step_loss = step_loss + LOSS_ONE;
      end
   end

   // step loss counter register
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
         step_loss <= LOSS_RST;
      else
         step_loss <= next_step_loss;
   end

   // open coil flags, set wins over clear
   // open flags latched per coil
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         x_open <= 1'b0;
         y_open <= 1'b0;
      end
      else
      begin
         x_open <= (x_open & ~rd_xpins) | x_coil_broken_flag_i;
         y_open <= (y_open & ~rd_ypins) | y_coil_broken_flag_i;
      end
   end

   // short flags, set wins over clear
   // pins registers clear shorts
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         x_short <= SHORT_RST;
         y_short <= SHORT_RST;
      end
      else
      begin
         x_short <= (x_short & ~{SHORT_W{rd_xpins}}) | x_short_evt;
         y_short <= (y_short & ~{SHORT_W{rd_ypins}}) | y_short_evt;
      end
   end

   // read multiplexer; real-time fields are sampled in the read cycle
   always_comb
   begin
      next_rd_data = UNMAPPED_DATA;
      if (addr_hit(rd_addr_i, ADDR_POS, 1'b1))
         next_rd_data = odd_byte(translator_position_i);
      else if (addr_hit(rd_addr_i, ADDR_BEMF, 1'b1))
         next_rd_data = odd_byte({back_emf_coil_select_i,
                                  back_emf_polarity_bad_i,
                                  back_emf_magnitude_i});
      else if (addr_hit(rd_addr_i, ADDR_RATE, 1'b1))
         next_rd_data = rotor_rate_i;
      else if (addr_hit(rd_addr_i, ADDR_LOSS, 1'b1))
         next_rd_data = odd_byte(step_loss);
      else if (addr_hit(rd_addr_i, ADDR_XPWM, 1'b0))
         next_rd_data = odd_byte({x_regulation_side_i,
                                  x_drive_polarity_i,
                                  x_duty_value_i});
      else if (addr_hit(rd_addr_i, ADDR_YPWM, 1'b0))
         next_rd_data = odd_byte({y_regulation_side_i,
                                  y_drive_polarity_i,
                                  y_duty_value_i});
      else if (addr_hit(rd_addr_i, ADDR_XPINS, 1'b0))
         next_rd_data = odd_byte({x_open, pin_sync[SYNC_M0],
                                  pin_sync[SYNC_M1], x_short});
      else if (addr_hit(rd_addr_i, ADDR_YPINS, 1'b0))
         next_rd_data = odd_byte({y_open, pin_sync[SYNC_RH],
                                  pin_sync[SYNC_DIR], y_short});
   end

   // answer register, one cycle after the request
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         rd_data_o  <= UNMAPPED_DATA;
         rd_valid_o <= 1'b0;
      end
      else
      begin
         rd_valid_o <= rd_en_i;
         if (rd_en_i)
            rd_data_o <= next_rd_data;
      end
   end

   // checks of the bank behaviour
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (srst_i);

   property p_pos_read;
      rd_en_i && addr_hit(rd_addr_i, ADDR_POS, 1'b1)
      |=> rd_data_o[POS_W-1:0] == $past(translator_position_i);
   endproperty
   a_pos_read: assert property (p_pos_read) // position
      else $error("position readout mismatch");

   property p_bemf_read;
      rd_en_i && addr_hit(rd_addr_i, ADDR_BEMF, 1'b1)
      |=> rd_data_o[BIT_HI] == $past(back_emf_coil_select_i)
          && rd_data_o[BIT_MID] == $past(back_emf_polarity_bad_i)
          && rd_data_o[MAG_W-1:0] == $past(back_emf_magnitude_i);
   endproperty
   a_bemf_read: assert property (p_bemf_read)
      else $error("back-emf readout mismatch");

   property p_rate_read;
      rd_en_i && (rd_addr_i == ADDR_RATE)
      |=> rd_data_o == $past(rotor_rate_i);
   endproperty
   a_rate_read: assert property (p_rate_read) // speed
      else $error("speed readout mismatch");

   property p_loss_count;
      lost_step && !rd_loss && step_loss != LOSS_MAX
      |=> step_loss == $past(step_loss) + LOSS_ONE;
   endproperty
   a_loss_count: assert property (p_loss_count) // counting
      else $error("ignored step not counted");

   property p_loss_sat;
      step_loss == LOSS_MAX && !rd_loss |=> step_loss == LOSS_MAX;
   endproperty
   a_loss_sat: assert property (p_loss_sat) // saturation
      else $error("step loss counter left its maximum");

   property p_xpwm_read;
      rd_en_i && rd_addr_i == ADDR_XPWM
      |=> rd_data_o[BIT_HI] == $past(x_regulation_side_i)
          && rd_data_o[BIT_MID] == $past(x_drive_polarity_i)
          && rd_data_o[MAG_W-1:0] == $past(x_duty_value_i);
   endproperty
   a_xpwm_read: assert property (p_xpwm_read)
      else $error("x pwm readout mismatch");

   property p_ypwm_read;
      rd_en_i && rd_addr_i == ADDR_YPWM
      |=> rd_data_o[BIT_HI] == $past(y_regulation_side_i)
          && rd_data_o[BIT_MID] == $past(y_drive_polarity_i)
          && rd_data_o[MAG_W-1:0] == $past(y_duty_value_i);
   endproperty
   a_ypwm_read: assert property (p_ypwm_read) // coil y
      else $error("y pwm readout mismatch");

   property p_open_set;
      x_coil_broken_flag_i ##1 rd_en_i && rd_addr_i == ADDR_XPINS
      |=> rd_data_o[BIT_HI];
   endproperty
   a_open_set: assert property (p_open_set) // open flag
      else $error("open coil x not reported");

   property p_mode_pins;
      rd_en_i && rd_addr_i == ADDR_XPINS
      |=> rd_data_o[BIT_MID] == $past(pin_sync[SYNC_M0])
          && rd_data_o[BIT_LO] == $past(pin_sync[SYNC_M1]);
   endproperty
   a_mode_pins: assert property (p_mode_pins) // mode pins
      else $error("step mode pin levels mismatch");

   property p_dir_pins;
      rd_en_i && rd_addr_i == ADDR_YPINS
      |=> rd_data_o[BIT_MID] == $past(pin_sync[SYNC_RH])
          && rd_data_o[BIT_LO] == $past(pin_sync[SYNC_DIR]);
   endproperty
   a_dir_pins: assert property (p_dir_pins) // run and direction
      else $error("run/hold or direction level mismatch");

   property p_short_set_wins;
      rd_xpins && x_pos_ground_fault_i |=> x_short[SHORT_W-1];
   endproperty
   a_short_set_wins: assert property (p_short_set_wins) // set wins
      else $error("x short event lost on clear");

   property p_yshort_keep;
      !rd_ypins |=> (y_short & $past(y_short)) == $past(y_short);
   endproperty
   a_yshort_keep: assert property (p_yshort_keep) // y shorts hold
      else $error("y short flag dropped without read");

   property p_odd_check;
      rd_valid_o && $past(has_check(rd_addr_i)) |-> ^rd_data_o;
   endproperty
   a_odd_check: assert property (p_odd_check) // odd check bit
      else $error("status byte does not have odd parity");

   property p_clear_on_read;
      rd_loss && !lost_step ##1 !lost_step |-> step_loss == LOSS_RST;
   endproperty
   a_clear_on_read: assert property (p_clear_on_read) // clear
      else $error("step loss not cleared by read");

   property p_alias_read;
      rd_en_i && rd_addr_i == (ADDR_POS | ADDR_ALIAS)
      |=> rd_data_o == odd_byte($past(translator_position_i));
   endproperty
   a_alias_read: assert property (p_alias_read) // alias
      else $error("alias address returned other contents");

   c_loss_sat: cover property (step_loss == LOSS_MAX ##1 lost_step);
   c_alias_clear: cover property (rd_en_i && rd_addr_i == (ADDR_LOSS | ADDR_ALIAS)
                                  && step_loss != LOSS_RST);
   c_set_and_clear: cover property (rd_ypins && y_coil_broken_flag_i);
   c_unmapped: cover property (rd_en_i && rd_addr_i == ADDR_ALIAS);
endmodule

// file: ssr_sync2.sv
// two-flop synchroniser for the asynchronous input pins
`timescale 1ns/1ps
module ssr_sync2
   import ssr_pkg::*;
(
   input  wire logic              clock_i,
   input  wire logic              srst_i,
   input  wire logic [SYNC_W-1:0] async_i,
   output logic      [SYNC_W-1:0] sync_o
);
   logic [SYNC_W-1:0] meta;

   // first stage feeds only the second stage
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         meta   <= SYNC_RST;
         sync_o <= SYNC_RST;
      end
      else
      begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end
endmodule

// file: stepper_status_readout_tb_top.sv
// self-checking bench of the stepper status readout
`timescale 1ns/1ps
module stepper_status_readout_tb_top;
   import ssr_pkg::*;
   logic              clock_i, srst_i, rd_en, rd_valid, bcoil, bpol, step, ign;
   logic              xside, xpol, yside, ypol, xopen, yopen, m0, m1, rh, dir;
   logic [ADDR_W-1:0] rd_addr;
   logic [BYTE_W-1:0] rd_data, rate;
   logic [POS_W-1:0]  pos;
   logic [MAG_W-1:0]  bmag, xduty, yduty;
   logic [3:0]        xf, yf;
   int                n_mismatch, checked, cycles;

   ssr_status_regs dut (.clock_i(clock_i), .srst_i(srst_i), .rd_en_i(rd_en),
      .rd_addr_i(rd_addr), .translator_position_i(pos), .back_emf_coil_select_i(bcoil),
      .back_emf_polarity_bad_i(bpol), .back_emf_magnitude_i(bmag), .rotor_rate_i(rate),
      .step_pulse_input_i(step), .steps_ignored_i(ign), .x_regulation_side_i(xside),
      .x_drive_polarity_i(xpol), .x_duty_value_i(xduty), .y_regulation_side_i(yside),
      .y_drive_polarity_i(ypol), .y_duty_value_i(yduty), .x_coil_broken_flag_i(xopen),
      .y_coil_broken_flag_i(yopen), .x_pos_ground_fault_i(xf[3]),
      .x_neg_ground_fault_i(xf[2]), .x_pos_supply_fault_i(xf[1]),
      .x_neg_supply_fault_i(xf[0]), .y_pos_ground_fault_i(yf[3]),
      .y_neg_ground_fault_i(yf[2]), .y_pos_supply_fault_i(yf[1]),
      .y_neg_supply_fault_i(yf[0]), .step_mode_bit0_level_i(m0),
      .step_mode_bit1_level_i(m1), .run_hold_input_level_i(rh),
      .rotation_sense_input_level_i(dir), .rd_data_o(rd_data), .rd_valid_o(rd_valid));

   ssr_host_model host (.clock_i(clock_i), .rd_data_i(rd_data), .rd_valid_i(rd_valid),
      .rd_en_o(rd_en), .rd_addr_o(rd_addr));

   // free running clock
   initial
   begin
      clock_i = 1'b0;
   end
   always #5 clock_i = ~clock_i;

   // odd check bit over seven payload bits
   function automatic logic [7:0] wp(input logic [6:0] v);
      return {~^v, v};
   endfunction

   task automatic cyc(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask

   task automatic results;
      if (n_mismatch == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // read one register and compare
   task automatic chk(input logic [ADDR_W-1:0] a, input logic [BYTE_W-1:0] e);
      logic [BYTE_W-1:0] d;
      logic              ok;
      host.rd(a, d, ok);
      checked++;
      if (ok !== 1'b1 || d !== e)
      begin
         $display("mismatch reg %h expected %h seen %h", a, e, d);
         n_mismatch++;
      end
   endtask

   // live fields, position, back-emf and speed at both addresses, pwm at its primary address only, seeded from one pattern
   task automatic t_live(input logic [7:0] v);
      pos   = v[6:0];
      bcoil = v[6];
      bpol  = v[5];
      bmag  = v[4:0];
      rate  = v;
      xside = v[6];
      xpol  = ~v[5];
      xduty = v[4:0];
      yside = ~v[6];
      ypol  = v[5];
      yduty = ~v[4:0];
      cyc(1);
      chk(5'h0a, wp(v[6:0]));
      chk(5'h1a, wp(v[6:0]));
      chk(5'h0b, wp(v[6:0]));
      chk(5'h1b, wp(v[6:0]));
      chk(5'h0c, v);
      chk(5'h1c, v);
      chk(5'h0e, wp({v[6], ~v[5], v[4:0]}));
      chk(5'h0f, wp({~v[6], v[5], ~v[4:0]}));
   endtask

   // step pin pulses slow enough for the pin synchroniser
   task automatic pulses(input int n);
      repeat (n)
      begin
         step = 1'b1;
         cyc(2);
         step = 1'b0;
         cyc(2);
      end
      cyc(3);
   endtask

   task automatic t_loss;
      ign = 1'b0;
      pulses(3);
      ign = 1'b1;
      pulses(5);
      chk(5'h0d, wp(7'h05));
      chk(5'h0d, wp(7'h00));
      pulses(130);
      ign = 1'b0;
      chk(5'h1d, wp(7'h7f));
      chk(5'h0d, wp(7'h00));
   endtask

   // one-cycle fault events, pins held; p is mode0, mode1, run/hold, direction
   task automatic t_pins(input logic [3:0] p, input logic [1:0] o,
                         input logic [3:0] fx, input logic [3:0] fy);
      {m0, m1, rh, dir} = p;
      {xopen, yopen} = o;
      xf = fx;
      yf = fy;
      cyc(1);
      {xopen, yopen, xf, yf} = 10'h000;
      cyc(3);
      chk(5'h1e, wp({o[1], p[3:2], fx}));
      chk(5'h1e, wp({1'b0, p[3:2], 4'h0}));
      chk(5'h1f, wp({o[0], p[1:0], fy}));
      chk(5'h1f, wp({1'b0, p[1:0], 4'h0}));
   endtask

   // hang guard
   always @(posedge clock_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         results();
      end
   end

   // reset held four cycles; outputs must sit at their reset values
   task automatic t_reset;
      srst_i = 1'b1;
      cyc(4);
      checked++;
      if ({rd_valid, rd_data} !== 9'h000)
      begin
         $display("mismatch reset outputs expected %h seen %h", 9'h000, {rd_valid, rd_data});
         n_mismatch++;
      end
      srst_i = 1'b0;
      cyc(1);
   endtask

   // fault levels held across reads: set wins over the clear
   task automatic t_race;
      xf    = 4'h8;
      yopen = 1'b1;
      cyc(1);
      chk(5'h1e, wp({1'b0, m0, m1, 4'h8}));
      chk(5'h1f, wp({1'b1, rh, dir, 4'h0}));
      xf    = 4'h0;
      yopen = 1'b0;
      chk(5'h1e, wp({1'b0, m0, m1, 4'h8}));
      chk(5'h1e, wp({1'b0, m0, m1, 4'h0}));
      chk(5'h1f, wp({1'b1, rh, dir, 4'h0}));
      chk(5'h1f, wp({1'b0, rh, dir, 4'h0}));
      // ignored pulse lands on the edge of a clearing read
      ign  = 1'b1;
      step = 1'b1;
      cyc(1);
      chk(5'h0d, wp(7'h00));
      step = 1'b0;
      ign  = 1'b0;
      chk(5'h0d, wp(7'h01));
   endtask

   // hole below the aliased range answers zero
   task automatic t_unmapped;
      chk(5'h10, 8'h00);
   endtask

   // reset in mid-run drops the count and all latched flags
   task automatic t_midreset;
      ign   = 1'b1;
      pulses(2);
      ign   = 1'b0;
      xf    = 4'hf;
      yopen = 1'b1;
      cyc(1);
      xf    = 4'h0;
      yopen = 1'b0;
      t_reset();
      chk(5'h0d, wp(7'h00));
      chk(5'h1e, wp({1'b0, m0, m1, 4'h0}));
      chk(5'h1f, wp({1'b0, rh, dir, 4'h0}));
   endtask

   // main sequence
   initial
   begin
      n_mismatch = 0;
      checked    = 0;
      cycles     = 0;
      srst_i     = 1'b1;
      {bcoil, bpol, step, ign, xside, xpol, yside, ypol} = 8'h00;
      {xopen, yopen, m0, m1, rh, dir} = 6'h00;
      {pos, bmag, xduty, yduty, rate, xf, yf} = 38'h00;
      t_reset();
      t_live(8'ha5);
      t_live(8'h5a);
      t_live(8'h00);
      t_live(8'hff);
      t_loss();
      t_pins(4'ha, 2'h2, 4'h5, 4'ha);
      t_pins(4'h5, 2'h1, 4'ha, 4'h5);
      t_race();
      t_unmapped();
      t_midreset();
      results();
   end
endmodule
